// ===== hdl/loopback_test_frame_generator.v
// Loopback test frame generator with CRC error counter and register file.
// Assumes an Avalon-MM master on i_sys_clk, a byte sink with ready, and
// a receive path on the same clock that flags returned loopback frames.
`timescale 1ns/1ns
`include "loopback_defines.vh"

module loopback_test_frame_generator (
    input  wire        i_sys_clk,
    input  wire        i_rst_b,
    input  wire [7:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    output wire        o_tx_valid,
    output wire [7:0]  o_tx_data,
    output wire        o_tx_sof,
    output wire        o_tx_eof,
    input  wire        i_tx_ready,
    input  wire        i_rx_done,
    input  wire        i_rx_crc_err,
    output wire        o_busy,
    output wire        o_irq
);

    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    // ==========================================================
    // Pattern decode
    function is_long;
        input [7:0] pat;
        begin
            is_long = (pat == `PAT_L_U_55) || (pat == `PAT_L_B_55) ||
                      (pat == `PAT_L_U_0F) || (pat == `PAT_L_B_0F) ||
                      (pat == `PAT_L_B_FF);
        end
    endfunction

    function is_bcast;
        input [7:0] pat;
        begin
            is_bcast = (pat == `PAT_S_B_55) || (pat == `PAT_L_B_55) ||
                       (pat == `PAT_S_B_0F) || (pat == `PAT_L_B_0F) ||
                       (pat == `PAT_L_B_FF);
        end
    endfunction

    function [15:0] fill_word;
        input [7:0] pat;
        begin
            case (pat)
                `PAT_S_U_0F, `PAT_L_U_0F,
                `PAT_S_B_0F, `PAT_L_B_0F: fill_word = `WORD_0F0F;
                `PAT_L_B_FF: fill_word = `WORD_FF00;
                default: fill_word = `WORD_55AA;
            endcase
        end
    endfunction

    // ==========================================================
    // Bus slave: one wait state, then the access completes
    reg         ack_q;
    wire        req = i_avs_read | i_avs_write;
    wire        wr_stb = i_avs_write & ack_q & i_avs_byteenable[0];
    wire [7:0]  wbyte = i_avs_writedata[7:0];

    assign o_avs_waitrequest = req & ~ack_q;

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ==========================================================
    // Registers
    reg  [7:0]  setup_q;
    reg  [7:0]  pattern_q;
    reg  [7:0]  crc_cnt_q;
    reg  [7:0]  sta_q [0:5];
    reg  [`IRQ_W-1:0] irq_st_q;
    reg  [`IRQ_W-1:0] irq_en_q;
    reg  [`IRQ_W-1:0] irq_ev;
    integer     k;

    wire wr_setup = wr_stb && (i_avs_address == `REG_SETUP);
    wire wr_clear = wr_setup && (wbyte == 8'h00);
    wire wr_start = wr_setup && (wbyte != 8'h00);
    wire rx_bad   = i_rx_done & i_rx_crc_err;
    reg  [7:0]  o_rd_mux;

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            setup_q   <= `SETUP_RST;
            pattern_q <= `PATTERN_RST;
            irq_en_q  <= {`IRQ_W{1'b0}};
            for (k = 0; k < 6; k = k + 1) begin
                sta_q[k] <= 8'h00;
            end
        end else if (wr_stb) begin
            if (i_avs_address == `REG_SETUP) begin
                setup_q <= wbyte;
            end
            if (i_avs_address == `REG_PATTERN) begin
                pattern_q <= wbyte;
            end
            if (i_avs_address == `REG_IRQ_ENABLE) begin
                irq_en_q <= wbyte[`IRQ_W-1:0];
            end
            for (k = 0; k < 6; k = k + 1) begin
                if (i_avs_address == `REG_STA_FIRST + k[7:0]) begin
                    sta_q[k] <= wbyte;
                end
            end
        end
    end

    // Error count: an error in the clearing cycle still counts once
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            crc_cnt_q <= 8'h00;
        end else if (wr_clear) begin
            crc_cnt_q <= {7'h00, rx_bad};
        end else if (rx_bad && crc_cnt_q != `CNT_MAX) begin
            crc_cnt_q <= crc_cnt_q + 8'h01;
        end
    end

    always @* begin
        case (i_avs_address)
            `REG_SETUP:      o_rd_mux = setup_q;
            `REG_PATTERN:    o_rd_mux = pattern_q;
            `REG_CRC_CNT:    o_rd_mux = crc_cnt_q;
            `REG_IRQ_STATUS: o_rd_mux = {5'h00, irq_st_q};
            `REG_IRQ_ENABLE: o_rd_mux = {5'h00, irq_en_q};
            default:         o_rd_mux = 8'h00;
        endcase
        if (i_avs_address >= `REG_STA_FIRST &&
            i_avs_address <= `REG_STA_LAST) begin
            o_rd_mux = sta_q[i_avs_address[2:0] - 3'h2];
        end
    end

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read & ~ack_q) begin
            o_avs_readdata <= {24'h000000, o_rd_mux};
        end
    end

    // ==========================================================
    // Interrupts: set wins over a clear in the same cycle
    wire [`IRQ_W-1:0] irq_clr = (wr_stb &&
        i_avs_address == `REG_IRQ_CLEAR) ? wbyte[`IRQ_W-1:0]
                                         : {`IRQ_W{1'b0}};

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_st_q <= {`IRQ_W{1'b0}};
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
        end
    end

    assign o_irq = |(irq_st_q & irq_en_q);

    // ==========================================================
    // Frame sequencer
    reg         state_q;
    reg  [10:0] idx_q;
    reg  [7:0]  left_q;
    reg  [7:0]  da_last_q;
    reg         long_q;
    reg         bcast_q;
    reg  [15:0] word_q;
    reg         vld_q;
    reg  [7:0]  data_q;
    reg         sof_q;
    reg         eof_q;
    reg  [7:0]  byte_d;
    wire [31:0] fcs;

    wire [10:0] len     = long_q ? `LEN_LONG : `LEN_SHORT;
    wire [10:0] fcs_idx = len - `FCS_BYTES;
    wire        load    = (state_q == ST_SEND) & (~vld_q | i_tx_ready);
    wire        last    = (idx_q == len - 11'h001);
    wire [10:0] fcs_off = idx_q - fcs_idx;

    always @* begin
        if (idx_q < `IDX_SA) begin
            if (bcast_q) begin
                byte_d = `BCAST_BYTE;
            end else if (idx_q == `IDX_SA - 11'h001) begin
                byte_d = da_last_q;
            end else begin
                byte_d = sta_q[idx_q[2:0]];
            end
        end else if (idx_q < `IDX_TYPE_HI) begin
            byte_d = sta_q[idx_q[2:0] - 3'h6];
        end else if (idx_q == `IDX_TYPE_HI) begin
            byte_d = `TYPE_HI;
        end else if (idx_q == `IDX_TYPE_LO) begin
            byte_d = `TYPE_LO;
        end else if (idx_q < fcs_idx) begin
            byte_d = idx_q[0] ? word_q[7:0] : word_q[15:8];
        end else begin
            case (fcs_off[1:0])
                2'h0:    byte_d = fcs[7:0];
                2'h1:    byte_d = fcs[15:8];
                2'h2:    byte_d = fcs[23:16];
                default: byte_d = fcs[31:24];
            endcase
        end
    end

    fcs_byte_engine u_fcs (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_en      (load && idx_q < fcs_idx),
        .i_start   (idx_q == 11'h000),
        .i_data    (byte_d),
        .o_fcs     (fcs)
    );

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q   <= ST_IDLE;
            idx_q     <= 11'h000;
            left_q    <= 8'h00;
            da_last_q <= 8'h00;
            long_q    <= 1'b0;
            bcast_q   <= 1'b0;
            word_q    <= `WORD_55AA;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_start) begin
                        state_q   <= ST_SEND;
                        left_q    <= wbyte;
                        idx_q     <= 11'h000;
                        da_last_q <= sta_q[5] + 8'h01;
                        long_q    <= is_long(pattern_q);
                        bcast_q   <= is_bcast(pattern_q);
                        word_q    <= fill_word(pattern_q);
                    end
                end
                ST_SEND: begin
                    if (load) begin
                        if (!last) begin
                            idx_q <= idx_q + 11'h001;
                        end else begin
                            idx_q     <= 11'h000;
                            left_q    <= left_q - 8'h01;
                            da_last_q <= da_last_q + 8'h01;
                            if (left_q == 8'h01) begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Output stage keeps data registered; ready only drains it
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            vld_q  <= 1'b0;
            data_q <= 8'h00;
            sof_q  <= 1'b0;
            eof_q  <= 1'b0;
        end else if (load) begin
            vld_q  <= 1'b1;
            data_q <= byte_d;
            sof_q  <= (idx_q == 11'h000);
            eof_q  <= last;
        end else if (i_tx_ready) begin
            vld_q  <= 1'b0;
        end
    end

    always @* begin
        irq_ev = {`IRQ_W{1'b0}};
        irq_ev[`IRQ_FRAME] = load & last;
        irq_ev[`IRQ_CRC]   = rx_bad;
        irq_ev[`IRQ_DONE]  = load & last & (left_q == 8'h01);
    end

    assign o_tx_valid = vld_q;
    assign o_tx_data  = data_q;
    assign o_tx_sof   = sof_q;
    assign o_tx_eof   = eof_q;
    assign o_busy     = state_q | vld_q;

endmodule // loopback_test_frame_generator

// ===== hdl/loopback_defines.vh
// Constants of the loopback test frame generator and its register map.
// Assumes a word-addressed Avalon-MM slave; word index = register index.
//
// How it works
// - 8-bit RW pattern register, reset zero, picks frame length, address and data.
// - 0x00: 64-byte unicast 55AA; 0x01: 1518-byte unicast 55AA.
// - 0x02: 64-byte broadcast 55AA; 0x04: 1518-byte broadcast 55AA.
// - 0x08: 64-byte unicast 0F0F; 0x10: 1518-byte unicast 0F0F.
// - 0x20: 64-byte broadcast 0F0F; 0x40: 1518-byte broadcast 0F0F.
// - 0x80: 1518-byte broadcast FF00; other values undefined.
// - Unicast DA is station address with last byte plus one.
// - Last DA byte grows by one on each following frame.
// - SA is the station address; type field is 0x0800.
// - Returned frame with CRC error bumps an 8-bit read-only counter.
// - Counter reads 0 to 255 in binary, resets to zero.
// - Writing zero to setup register clears the CRC error counter.
// - Writing 1 to 100 to setup register sends that many frames; default 7.
`ifndef LOOPBACK_DEFINES_VH
`define LOOPBACK_DEFINES_VH

// ==========================================================
// Register indices
`define REG_SETUP        8'h44
`define REG_PATTERN      8'h45
`define REG_CRC_CNT      8'h46
`define REG_STA_FIRST    8'h52
`define REG_STA_LAST     8'h57
`define REG_IRQ_STATUS   8'h60
`define REG_IRQ_ENABLE   8'h61
`define REG_IRQ_CLEAR    8'h62

// ==========================================================
// Reset values and limits
`define SETUP_RST        8'h07
`define PATTERN_RST      8'h00
`define CNT_MAX          8'hFF
`define COUNT_MAX        8'h64

// ==========================================================
// Pattern codes
`define PAT_S_U_55       8'h00
`define PAT_L_U_55       8'h01
`define PAT_S_B_55       8'h02
`define PAT_L_B_55       8'h04
`define PAT_S_U_0F       8'h08
`define PAT_L_U_0F       8'h10
`define PAT_S_B_0F       8'h20
`define PAT_L_B_0F       8'h40
`define PAT_L_B_FF       8'h80

// ==========================================================
// Frame layout
`define WORD_55AA        16'h55AA
`define WORD_0F0F        16'h0F0F
`define WORD_FF00        16'hFF00
`define LEN_SHORT        11'h040
`define LEN_LONG         11'h5EE
`define FCS_BYTES        11'h004
`define IDX_SA           11'h006
`define IDX_TYPE_HI      11'h00C
`define IDX_TYPE_LO      11'h00D
`define TYPE_HI          8'h08
`define TYPE_LO          8'h00
`define BCAST_BYTE       8'hFF

// ==========================================================
// Frame check sequence
`define CRC_INIT         32'hFFFFFFFF
`define CRC_POLY_REFL    32'hEDB88320

// ==========================================================
// Interrupt status bits
`define IRQ_W            3
`define IRQ_FRAME        0
`define IRQ_CRC          1
`define IRQ_DONE         2

`endif

// ===== hdl/fcs_byte_engine.v
// Ethernet CRC-32, one byte per cycle, LSB of each byte first.
// Assumes the caller holds i_en only for bytes that are to be covered.
`timescale 1ns/1ns
`include "loopback_defines.vh"

module fcs_byte_engine (
    input  wire        i_sys_clk,
    input  wire        i_rst_b,
    input  wire        i_en,
    input  wire        i_start,
    input  wire [7:0]  i_data,
    output wire [31:0] o_fcs
);

    reg  [31:0] crc_q;
    reg  [31:0] crc_d;
    reg  [31:0] seed;
    integer     i;

    // ==========================================================
    // Next value
    // A first byte restarts from the seed so no clear cycle is needed
    always @* begin
        seed  = i_start ? `CRC_INIT : crc_q;
        crc_d = seed;
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_d[0] ^ i_data[i]) begin
                crc_d = (crc_d >> 1) ^ `CRC_POLY_REFL;
            end else begin
                crc_d = crc_d >> 1;
            end
        end
    end

    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            crc_q <= `CRC_INIT;
        end else if (i_en) begin
            crc_q <= crc_d;
        end
    end

    assign o_fcs = ~crc_q;

endmodule // fcs_byte_engine

// ===== dv/loopback_tfg_chk.sv
// Port-level assertions for the loopback test frame generator.
// Assumes one clock domain and the registered byte stream of the note.
`timescale 1ns/1ns
module loopback_tfg_chk (
    input wire logic        i_sys_clk,
    input wire logic        i_rst_b,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_tx_valid,
    input wire logic [7:0]  o_tx_data,
    input wire logic        o_tx_sof,
    input wire logic        o_tx_eof,
    input wire logic        i_tx_ready
);
    // ==========================================================
    // Byte position inside the current frame
    logic [10:0] idx_q;
    logic        req;
    assign req = i_avs_read | i_avs_write;
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            idx_q <= 11'h000;
        else if (o_tx_valid && i_tx_ready)
            idx_q <= o_tx_eof ? 11'h000 : idx_q + 11'h001;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // ==========================================================
    // Properties
    chk_wait_first: assert property (req && !$past(req) |->
        o_avs_waitrequest) else $error("wait state missing");
    chk_wait_one: assert property (req && o_avs_waitrequest |=>
        !o_avs_waitrequest) else $error("wait state too long");
    chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid
        && $stable(o_tx_data) && $stable(o_tx_eof)) else $error("tx hold");
    chk_eof_len: assert property (o_tx_valid && o_tx_eof |->
        idx_q == 11'h03F || idx_q == 11'h5ED) else $error("frame length");
    chk_sof_first: assert property (o_tx_valid |->
        o_tx_sof == (idx_q == 11'h000)) else $error("sof position");
    chk_type_hi: assert property (o_tx_valid && idx_q == 11'h00C |->
        o_tx_data == 8'h08) else $error("type high byte");
    chk_type_lo: assert property (o_tx_valid && idx_q == 11'h00D |->
        o_tx_data == 8'h00) else $error("type low byte");
    chk_rd_upper: assert property (i_avs_read && !o_avs_waitrequest |->
        o_avs_readdata[31:8] == 24'h000000) else $error("read upper bits");
endmodule // loopback_tfg_chk

bind loopback_test_frame_generator loopback_tfg_chk loopback_tfg_chk_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_sof(o_tx_sof), .o_tx_eof(o_tx_eof),
    .i_tx_ready(i_tx_ready));

// ===== dv/loopback_far_end.sv
// Remote terminal model: takes frame bytes, loops each frame back.
// Assumes the bench sets i_slow to stall and i_bad to corrupt returns.
`timescale 1ns/1ns
module loopback_far_end (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_valid,
    input  wire logic [7:0] i_data,
    input  wire logic       i_eof,
    input  wire logic       i_slow,
    input  wire logic       i_bad,
    output logic            o_ready,
    output logic            o_done,
    output logic            o_crc_err
);
    logic [7:0] buf_q [0:2047];
    logic [7:0] da5_q [0:255];
    int         idx_q;
    int         len_q;
    int         frames_q;
    logic       take;
    assign take = i_valid && o_ready;
    always @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ready   <= 1'b0;
            o_done    <= 1'b0;
            o_crc_err <= 1'b0;
            idx_q     <= 0;
            frames_q  <= 0;
        end else begin
            // Slow mode halves throughput so the sender must hold bytes
            o_ready   <= !i_slow || !o_ready;
            o_done    <= take && i_eof;
            // Error flag toggles between returns so it never looks valid
            o_crc_err <= (take && i_eof) ? i_bad : !o_crc_err;
            if (take) begin
                buf_q[idx_q] <= i_data;
                if (idx_q == 5)
                    da5_q[frames_q[7:0]] <= i_data;
                idx_q <= i_eof ? 0 : idx_q + 1;
                if (i_eof) begin
                    len_q    <= idx_q + 1;
                    frames_q <= frames_q + 1;
                end
            end
        end
    end
endmodule // loopback_far_end

// ===== dv/test_loopback_test_frame_generator.sv
// Self-checking bench for the loopback test frame generator.
// Assumes the far end model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module test_loopback_test_frame_generator;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic        slow = 1'b0;
    logic        bad = 1'b0;
    wire  [31:0] rdata;
    wire  [7:0]  tx_data;
    wire         waitreq, tx_valid, tx_sof, tx_eof, ready, done, crc_err;
    wire         busy, irq;
    logic [31:0] rdv;
    logic [7:0]  sta [0:5];
    int          mismatches = 0;
    int          tests_run = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    loopback_test_frame_generator loopback_test_frame_generator_inst (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .o_tx_sof(tx_sof), .o_tx_eof(tx_eof),
        .i_tx_ready(ready), .i_rx_done(done), .i_rx_crc_err(crc_err),
        .o_busy(busy), .o_irq(irq));
    loopback_far_end loopback_far_end_inst (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_valid(tx_valid),
        .i_data(tx_data), .i_eof(tx_eof), .i_slow(slow), .i_bad(bad),
        .o_ready(ready), .o_done(done), .o_crc_err(crc_err));
    // ==========================================================
    // Reporting and bus tasks
    task summarize;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task timeout(input string n);
        mismatches++;
        $display("unexpected %s expected done seen hang", n);
        summarize;
    endtask
    // Called just after a rising edge; returns just after one
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
             input logic [3:0] be);
        int n;
        n = 0;
        i_avs_address <= a;
        i_avs_writedata <= {24'h000000, d};
        i_avs_byteenable <= be;
        i_avs_read <= !w;
        i_avs_write <= w;
        do begin
            @(posedge i_sys_clk);
            n++;
            if (n > 20)
                timeout("bus");
        end while (waitreq);
        rdv = rdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask
    task rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00, 4'h1);
    endtask
    task wait_idle(input int max);
        int n;
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
            if (n > max)
                timeout("burst");
        end while (busy);
        repeat (4) @(posedge i_sys_clk);
    endtask
    // ==========================================================
    // Scenarios
    task regs_reset;
        int i;
        rd(8'h44); chk("setup", 32'h00000007, rdv);
        rd(8'h45); chk("pattern", 32'h00000000, rdv);
        rd(8'h46); chk("crc_count", 32'h00000000, rdv);
        rd(8'h70); chk("unmapped", 32'h00000000, rdv);
        bus(1'b1, 8'h45, 8'h10, 4'h0);
        rd(8'h45); chk("pattern_no_be", 32'h00000000, rdv);
        for (i = 0; i < 6; i++)
            wr(8'h52 + i[7:0], sta[i]);
    endtask
    task frame_pat(input logic [7:0] p, input int len, input logic bc,
                   input logic [15:0] w);
        int f, i, k;
        logic [31:0] c;
        f = loopback_far_end_inst.frames_q;
        wr(8'h45, p);
        rd(8'h45); chk("pattern", {24'h000000, p}, rdv);
        wr(8'h44, 8'h01);
        wait_idle(4000);
        chk("frames", f + 1, loopback_far_end_inst.frames_q);
        chk("length", len, loopback_far_end_inst.len_q);
        c = 32'hFFFFFFFF;
        for (i = 0; i < len; i++) begin
            if (i < 6) begin
                chk("da", bc ? 8'hFF : (i == 5 ? sta[5] + 8'h01 : sta[i]),
                    loopback_far_end_inst.buf_q[i]);
                chk("sa", sta[i], loopback_far_end_inst.buf_q[i + 6]);
            end else if (i >= 14 && i < len - 4)
                chk("payload", i[0] ? w[7:0] : w[15:8],
                    loopback_far_end_inst.buf_q[i]);
            for (k = 0; k < 8; k++)
                c = (c >> 1) ^ ((c[0] ^ loopback_far_end_inst.buf_q[i][k])
                    ? 32'hEDB88320 : 32'h00000000);
        end
        chk("fcs_residue", 32'hDEBB20E3, c);
    endtask
    task crc_irq;
        int f, i;
        f = loopback_far_end_inst.frames_q;
        bad <= 1'b1;
        wr(8'h44, 8'h03);
        wait_idle(1000);
        for (i = 0; i < 3; i++)
            chk("da_step", 8'(sta[5] + 8'h01 + i[7:0]),
                loopback_far_end_inst.da5_q[(f + i) % 256]);
        rd(8'h46); chk("crc_count", 32'h00000003, rdv);
        chk("irq_masked", 32'h00000000, irq);
        wr(8'h61, 8'h02);
        chk("irq_on", 32'h00000001, irq);
        rd(8'h60); chk("status_crc", 32'h00000001, rdv[1]);
        wr(8'h62, 8'h02);
        chk("irq_cleared", 32'h00000000, irq);
        rd(8'h62); chk("clear_reg", 32'h00000000, rdv);
        wr(8'h44, 8'h00);
        rd(8'h46); chk("crc_cleared", 32'h00000000, rdv);
    endtask
    task crc_sat;
        wr(8'h44, 8'h64);
        wait_idle(20000);
        wr(8'h44, 8'h64);
        wait_idle(20000);
        wr(8'h44, 8'h37);
        wait_idle(20000);
        rd(8'h46); chk("crc_255", 32'h000000FF, rdv);
        wr(8'h44, 8'h01);
        wait_idle(1000);
        rd(8'h46); chk("crc_hold", 32'h000000FF, rdv);
        wr(8'h46, 8'h00);
        rd(8'h46); chk("crc_ro", 32'h000000FF, rdv);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        sta = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'hFE};
        repeat (10) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        @(posedge i_sys_clk);
        regs_reset;
        slow <= 1'b1;
        frame_pat(8'h00, 64, 1'b0, 16'h55AA);
        frame_pat(8'h01, 1518, 1'b0, 16'h55AA);
        frame_pat(8'h02, 64, 1'b1, 16'h55AA);
        frame_pat(8'h04, 1518, 1'b1, 16'h55AA);
        frame_pat(8'h08, 64, 1'b0, 16'h0F0F);
        frame_pat(8'h10, 1518, 1'b0, 16'h0F0F);
        frame_pat(8'h20, 64, 1'b1, 16'h0F0F);
        frame_pat(8'h40, 1518, 1'b1, 16'h0F0F);
        frame_pat(8'h80, 1518, 1'b1, 16'hFF00);
        slow <= 1'b0;
        wr(8'h45, 8'h00);
        crc_irq;
        crc_sat;
        summarize;
    end
endmodule // test_loopback_test_frame_generator
